// [rtl/command_register_serial_access.sv]
`timescale 1ns/100ps
`default_nettype none
module command_register_serial_access
  import cmd_reg_pkg::*;
#(
  parameter int unsigned RAW_W = SAMPLE_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic io_write,
  input wire logic io_word,
  input wire logic [ADDR_W-1:0] io_addr,
  input wire logic [15:0] io_wdata,
  input wire logic strobe_write,
  input wire logic software_acq_start,
  input wire logic external_acq_trigger_n,
  input wire logic conversion_request,
  input wire logic [RAW_W-1:0] sample_raw,
  output logic cal_store_select,
  output logic cal_store_clock,
  output logic trim_converter_clock,
  output logic serial_bit_out,
  output logic trim_converter_load,
  output logic dither_enable,
  output logic conversion_inhibit,
  output logic cal_switch,
  output logic acquisition_enable,
  output logic multi_channel_enable,
  output logic interval_scan_select,
  output logic sequence_clock_divide,
  output logic conversion_count_chain,
  output logic input_reference_select,
  output logic input_topology_select,
  output logic polarity_select,
  output logic event_pulse,
  output logic acq_start_pulse,
  output logic conversion_go,
  output logic trim_load_pulse,
  output logic [15:0] sample_word
);
  logic [15:0] cmd_q;
  logic [15:0] cmd_d;
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;
  logic strobe_q;
  logic acq_q;
  logic conv_q;
  logic load_q;
  load_state_t lstate_q;
  load_state_t lstate_d;

  // Byte writes and other offsets leave the command word alone
  wire cmd_hit = io_write & io_word & (io_addr == BOARD_COMMAND_ONE_OFF);
  assign cmd_d = cmd_hit ? io_wdata : cmd_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_q <= BOARD_COMMAND_ONE_RST;
    end else begin
      cmd_q <= cmd_d;
    end
  end

  // Pins are register bits, the store clock gated by select, so ordering of edges is host paced
  assign cal_store_select = cmd_q[CAL_STORE_SELECT_BIT];
  assign serial_bit_out = cmd_q[SERIAL_BIT_OUT_BIT];
  assign trim_converter_clock = cmd_q[SERIAL_CLOCK_BIT];
  // Store clock gated by select so a deselected store sees no edges
  assign cal_store_clock = cmd_q[SERIAL_CLOCK_BIT] & cmd_q[CAL_STORE_SELECT_BIT];
  assign trim_converter_load = cmd_q[TRIM_CONVERTER_LOAD_BIT];
  // No read path; reserved bit 11 is kept but drives nothing
  assign dither_enable = cmd_q[DITHER_ENABLE_BIT];
  assign conversion_inhibit = cmd_q[CONVERSION_INHIBIT_BIT];
  assign cal_switch = cmd_q[CAL_SWITCH_BIT];
  assign acquisition_enable = cmd_q[ACQUISITION_ENABLE_BIT];
  assign multi_channel_enable = cmd_q[MULTI_CHANNEL_ENABLE_BIT];
  assign interval_scan_select = cmd_q[INTERVAL_SCAN_SELECT_BIT];
  assign sequence_clock_divide = cmd_q[SEQUENCE_CLOCK_DIVIDE_BIT];
  // Zero selects 16-bit count, the asterisked name
  assign conversion_count_chain = cmd_q[CONVERSION_COUNT_WIDTH_BIT];
  assign input_reference_select = cmd_q[INPUT_REFERENCE_SELECT_BIT];
  assign input_topology_select = cmd_q[INPUT_TOPOLOGY_SELECT_BIT];
  assign polarity_select = cmd_q[POLARITY_SELECT_BIT];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ~external_acq_trigger_n;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  wire ext_rise = ext_s2_q & ~ext_s3_q;
  wire acq_req = software_acq_start | ext_rise;
  wire acq_d = acq_req & cmd_q[ACQUISITION_ENABLE_BIT];
  wire conv_d = conversion_request & ~cmd_q[CONVERSION_INHIBIT_BIT];

  // Load pulse fires once per rising edge of the load bit
  always_comb begin
    lstate_d = lstate_q;
    case (lstate_q)
      SER_IDLE: if (cmd_q[TRIM_CONVERTER_LOAD_BIT]) lstate_d = SER_LOADING;
      SER_LOADING: if (!cmd_q[TRIM_CONVERTER_LOAD_BIT]) lstate_d = SER_IDLE;
      default: lstate_d = SER_IDLE;
    endcase
  end
  wire load_d = (lstate_q == SER_IDLE) & cmd_q[TRIM_CONVERTER_LOAD_BIT];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strobe_q <= 1'b0;
      acq_q <= 1'b0;
      conv_q <= 1'b0;
      load_q <= 1'b0;
      lstate_q <= SER_IDLE;
    end else begin
      strobe_q <= strobe_write;
      acq_q <= acq_d;
      conv_q <= conv_d;
      load_q <= load_d;
      lstate_q <= lstate_d;
    end
  end

  assign event_pulse = strobe_q;
  assign acq_start_pulse = acq_q;
  assign conversion_go = conv_q;
  assign trim_load_pulse = load_q;

  sample_extend #(
    .IN_W(RAW_W)
  ) u_ext (
    .clk(clk),
    .rst(rst),
    .bipolar(cmd_q[POLARITY_SELECT_BIT]),
    .raw(sample_raw),
    .word(sample_word)
  );

  property p_word_write;
    @(posedge clk) disable iff (rst)
    cmd_hit |=> cmd_q == $past(io_wdata);
  endproperty
  a_word_write: assert property (p_word_write)
    else $error("command word not stored");
  property p_byte_ignored;
    @(posedge clk) disable iff (rst)
    (io_write & ~io_word) |=> $stable(cmd_q);
  endproperty
  a_byte_ignored: assert property (p_byte_ignored)
    else $error("byte write altered command word");
  property p_select;
    @(posedge clk) disable iff (rst)
    cmd_hit |=> cal_store_select == $past(io_wdata[CAL_STORE_SELECT_BIT]);
  endproperty
  a_select: assert property (p_select)
    else $error("store select not following write");
  property p_serial_data;
    @(posedge clk) disable iff (rst)
    cmd_hit |=> serial_bit_out == $past(io_wdata[SERIAL_BIT_OUT_BIT]);
  endproperty
  a_serial_data: assert property (p_serial_data)
    else $error("serial data not following write");
  property p_store_quiet;
    @(posedge clk) disable iff (rst)
    !cal_store_select |-> !cal_store_clock;
  endproperty
  a_store_quiet: assert property (p_store_quiet)
    else $error("store clocked while deselected");
  property p_conv_gate;
    @(posedge clk) disable iff (rst)
    cmd_q[CONVERSION_INHIBIT_BIT] |=> !conversion_go;
  endproperty
  a_conv_gate: assert property (p_conv_gate)
    else $error("conversion while inhibited");
  property p_acq_gate;
    @(posedge clk) disable iff (rst)
    !cmd_q[ACQUISITION_ENABLE_BIT] |=> !acq_start_pulse;
  endproperty
  a_acq_gate: assert property (p_acq_gate)
    else $error("acquisition start while disabled");
  property p_ext_start;
    @(posedge clk) disable iff (rst)
    ext_rise & cmd_q[ACQUISITION_ENABLE_BIT] |=> acq_start_pulse;
  endproperty
  a_ext_start: assert property (p_ext_start)
    else $error("enabled external trigger lost");
  property p_strobe;
    @(posedge clk) disable iff (rst)
    strobe_write |=> event_pulse;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("strobe lost");
  property p_load_once;
    @(posedge clk) disable iff (rst)
    trim_load_pulse |=> !trim_load_pulse;
  endproperty
  a_load_once: assert property (p_load_once)
    else $error("load pulse too long");
  property p_load_rise;
    @(posedge clk) disable iff (rst)
    $rose(cmd_q[TRIM_CONVERTER_LOAD_BIT]) |=> trim_load_pulse;
  endproperty
  a_load_rise: assert property (p_load_rise)
    else $error("load pulse missing after load bit rise");
  property p_dither;
    @(posedge clk) disable iff (rst)
    cmd_hit |=> dither_enable == $past(io_wdata[DITHER_ENABLE_BIT]);
  endproperty
  a_dither: assert property (p_dither)
    else $error("dither not following write");
endmodule
`default_nettype wire

// [rtl/cmd_reg_pkg.sv]
package cmd_reg_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam logic [4:0] BOARD_COMMAND_ONE_OFF = 5'h00;
  localparam logic [15:0] BOARD_COMMAND_ONE_RST = 16'h0000;
  localparam int unsigned CAL_STORE_SELECT_BIT = 15;
  localparam int unsigned SERIAL_BIT_OUT_BIT = 14;
  localparam int unsigned SERIAL_CLOCK_BIT = 13;
  localparam int unsigned TRIM_CONVERTER_LOAD_BIT = 12;
  localparam int unsigned RESERVED_BIT = 11;
  localparam int unsigned DITHER_ENABLE_BIT = 10;
  localparam int unsigned CONVERSION_INHIBIT_BIT = 9;
  localparam int unsigned CAL_SWITCH_BIT = 8;
  localparam int unsigned ACQUISITION_ENABLE_BIT = 7;
  localparam int unsigned MULTI_CHANNEL_ENABLE_BIT = 6;
  localparam int unsigned INTERVAL_SCAN_SELECT_BIT = 5;
  localparam int unsigned SEQUENCE_CLOCK_DIVIDE_BIT = 4;
  localparam int unsigned CONVERSION_COUNT_WIDTH_BIT = 3;
  localparam int unsigned INPUT_REFERENCE_SELECT_BIT = 2;
  localparam int unsigned INPUT_TOPOLOGY_SELECT_BIT = 1;
  localparam int unsigned POLARITY_SELECT_BIT = 0;
  localparam int unsigned SAMPLE_W = 12;
  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_LOADING = 2'b01
  } load_state_t;
endpackage

// [rtl/sample_extend.sv]
`timescale 1ns/100ps
`default_nettype none
module sample_extend
  import cmd_reg_pkg::*;
#(
  parameter int unsigned IN_W = SAMPLE_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic bipolar,
  input wire logic [IN_W-1:0] raw,
  output logic [15:0] word
);
  // A full 16-bit code would leave no room for the sign fill
  if (IN_W < 2 || IN_W > 15) begin : g_bad_in_w
    $error("sample_extend: IN_W out of range");
  end

  wire [15:0] ext_w;
  // Bipolar fills upper bits with sign, unipolar with zero
  assign ext_w = {{(16-IN_W){bipolar & raw[IN_W-1]}}, raw};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word <= 16'h0000;
    end else begin
      word <= ext_w;
    end
  end

  property p_sign_ext;
    @(posedge clk) disable iff (rst)
    1'b1 |=> word[15] == ($past(bipolar) & $past(raw[IN_W-1]));
  endproperty
  a_sign_ext: assert property (p_sign_ext)
    else $error("sample sign extension wrong");
endmodule
`default_nettype wire

// [testbench/host_io_model.sv]
`timescale 1ns/100ps
`default_nettype none
module host_io_model
  import cmd_reg_pkg::*;
(
  input wire logic clk,
  output logic io_write,
  output logic io_word,
  output logic [ADDR_W-1:0] io_addr,
  output logic [15:0] io_wdata
);
  initial begin
    io_write = 1'b0;
    io_word = 1'b0;
    io_addr = '0;
    io_wdata = 16'h0000;
  end
  // Reserved bit always sent low
  task automatic put(input logic [ADDR_W-1:0] a, input logic [15:0] w, input logic wide);
    @(posedge clk);
    io_write <= 1'b1;
    io_word <= wide;
    io_addr <= a;
    io_wdata <= w & 16'hF7FF;
  endtask
  // Released bus must not look like the last word
  task automatic idle();
    @(posedge clk);
    io_write <= 1'b0;
    io_wdata <= ~io_wdata;
  endtask
endmodule
`default_nettype wire

// [testbench/command_register_serial_access_test.sv]
`timescale 1ns/100ps
`default_nettype none
module command_register_serial_access_test
  import cmd_reg_pkg::*;
;
  logic clk, rst, strobe_write, software_acq_start, external_acq_trigger_n, conversion_request;
  logic io_write, io_word, fire, taken_q, fire_q;
  logic [ADDR_W-1:0] io_addr;
  logic [15:0] io_wdata, sample_word, shadow, lv;
  logic [SAMPLE_W-1:0] sample_raw;
  logic cal_store_select, cal_store_clock, trim_converter_clock, serial_bit_out;
  logic trim_converter_load, dither_enable, conversion_inhibit, cal_switch, acquisition_enable;
  logic multi_channel_enable, interval_scan_select, sequence_clock_divide, conversion_count_chain;
  logic input_reference_select, input_topology_select, polarity_select;
  logic event_pulse, acq_start_pulse, conversion_go, trim_load_pulse;
  logic [15:0] lvq[$];
  logic [18:0] pq[$];
  int n_mismatch, comparisons, n_trim, n_acq, t0;
  command_register_serial_access dut_u (.clk, .rst, .io_write, .io_word, .io_addr, .io_wdata,
    .strobe_write, .software_acq_start, .external_acq_trigger_n, .conversion_request,
    .sample_raw, .cal_store_select, .cal_store_clock, .trim_converter_clock, .serial_bit_out,
    .trim_converter_load, .dither_enable, .conversion_inhibit, .cal_switch, .acquisition_enable,
    .multi_channel_enable, .interval_scan_select, .sequence_clock_divide,
    .conversion_count_chain, .input_reference_select, .input_topology_select, .polarity_select,
    .event_pulse, .acq_start_pulse, .conversion_go, .trim_load_pulse, .sample_word);
  host_io_model host_u (.clk, .io_write, .io_word, .io_addr, .io_wdata);
  // Bit 11 slot carries the gated store clock, as the register bit itself has no output
  assign lv = {cal_store_select, serial_bit_out, trim_converter_clock, trim_converter_load,
    cal_store_clock, dither_enable, conversion_inhibit, cal_switch, acquisition_enable,
    multi_channel_enable, interval_scan_select, sequence_clock_divide, conversion_count_chain,
    input_reference_select, input_topology_select, polarity_select};
  task automatic chk_word(input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_pulse(input logic [18:0] e, input logic [18:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] w);
    shadow = w & 16'hF7FF;
    lvq.push_back(shadow | (16'(shadow[13] & shadow[15]) << 11));
    host_u.put(BOARD_COMMAND_ONE_OFF, w, 1'b1);
  endtask
  task automatic fire_in(input logic [2:0] f);
    logic [SAMPLE_W-1:0] r;
    r = SAMPLE_W'($urandom);
    pq.push_back({f & {1'b1, shadow[7], ~shadow[9]},
      shadow[0] ? {{(16 - SAMPLE_W){r[SAMPLE_W-1]}}, r} : 16'(r)});
    @(posedge clk);
    {strobe_write, software_acq_start, conversion_request} <= f;
    sample_raw <= r;
    fire <= 1'b1;
    @(posedge clk);
    {strobe_write, software_acq_start, conversion_request} <= 3'h0;
    fire <= 1'b0;
  endtask
  task automatic ext_check(input int e);
    int a0;
    a0 = n_acq;
    @(posedge clk);
    external_acq_trigger_n <= 1'b0;
    repeat (2) @(posedge clk);
    external_acq_trigger_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk_word(16'(e), 16'(n_acq - a0));
  endtask
  task automatic report_and_stop();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (taken_q) chk_word(lvq.size() ? lvq.pop_front() : 16'hXXXX, lv);
    if (fire_q) chk_pulse(pq.size() ? pq.pop_front() : 19'hXXXXX,
      {event_pulse, acq_start_pulse, conversion_go, sample_word});
    taken_q <= io_write & io_word & (io_addr == BOARD_COMMAND_ONE_OFF);
    fire_q <= fire;
    n_trim <= n_trim + int'(trim_load_pulse);
    n_acq <= n_acq + int'(acq_start_pulse);
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    {rst, external_acq_trigger_n} = 2'b11;
    {strobe_write, software_acq_start, conversion_request, fire, taken_q, fire_q} = 6'h00;
    sample_raw = '0;
    shadow = 16'h0000;
    void'($urandom(32'h8094));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk_word(16'h0000, lv);
    wr(16'h2000);
    wr(16'h0000);
    for (int i = 0; i < 16; i++) wr(16'h0001 << i);
    wr(16'hFFFF);
    repeat (8) wr(16'($urandom) & 16'h7FFF);
    host_u.put(BOARD_COMMAND_ONE_OFF, 16'h0280, 1'b0);
    host_u.put(5'h02, 16'h0280, 1'b1);
    host_u.idle();
    @(negedge clk);
    chk_word(shadow, lv);
    wr(16'h0081);
    host_u.idle();
    for (int i = 0; i < 8; i++) fire_in(3'(i));
    wr(16'h0200);
    host_u.idle();
    for (int i = 0; i < 8; i++) fire_in(3'(i));
    ext_check(0);
    t0 = n_trim;
    wr(16'h1000);
    wr(16'h0080);
    host_u.idle();
    repeat (6) @(posedge clk);
    chk_word(16'h0001, 16'(n_trim - t0));
    ext_check(1);
    rst <= 1'b1;
    @(negedge clk);
    chk_word(16'h0000, lv);
    @(posedge clk);
    rst <= 1'b0;
    report_and_stop();
  end
endmodule
`default_nettype wire
